// *** pkg/acm_defines.svh ***
/*
  Constants of the converter mode-control block: latencies, wake-up times,
  strap level codes and test patterns.
  Assumes strap levels arrive already quantised to two-bit codes,
  0 = ground up to 3 = full supply.
*/
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

// Core pipeline latency in sampling-clock cycles
`define ACM_CORE_LAT 12
// Serializer latencies per output option
`define ACM_SER_LAT_DDR1W 1
`define ACM_SER_LAT_SDR2W 2
`define ACM_SER_LAT_DDR2W 2
// Sampling clock rate in MHz and wake-up time in microseconds
`define ACM_CLK_MHZ 20
`define ACM_WAKE_US 100
// Longest wake-up time in whole cycles, microseconds times MHz
`define ACM_WAKE_CYC (`ACM_WAKE_US * `ACM_CLK_MHZ)
// Channel standby exit time, already in cycles
`define ACM_STBY_CYC 200
// Lane strap codes with special meaning
`define ACM_LANE_UNUSED 2'h1
`define ACM_LANE_SDR2W 2'h2
// Test patterns
`define ACM_SYNC_PAT 12'hfc0
`define ACM_DESKEW_PAT 12'haaa
// Width of the sequence tag carried with each word
`define ACM_TAG_W 8

`endif

// *** pkg/acm_pkg.sv ***
/*
  Types of the converter mode-control block.
  Assumes acm_defines.svh is on the include path.
*/
`include "acm_defines.svh"

package acm_pkg;

  // Configuration scheme
  typedef enum logic [1:0] {
    SCH_STRAP = 2'h0,
    SCH_SERIAL = 2'h1,
    SCH_BOTH = 2'h2
  } acm_scheme_t;

  // Test pattern and global power mode
  typedef enum logic [3:0] {
    PAT_NORMAL = 4'h1,
    PAT_SYNC = 4'h2,
    PAT_PDN = 4'h4,
    PAT_DESKEW = 4'h8
  } acm_pat_t;

  // Power state
  typedef enum logic [2:0] {
    PWR_DOWN = 3'h1,
    PWR_WAKE = 3'h2,
    PWR_RUN = 3'h4
  } acm_pwr_t;

  // Decoded operating configuration
  typedef struct packed {
    logic lane2w;
    logic ddr;
    logic cfg_unused;
    logic fac14;
    logic cap_rise;
    logic msb_first;
    logic twos;
    logic gain35;
    logic int_ref;
  } acm_cfg_t;

  // Strap pin levels as sampled
  typedef struct packed {
    logic [1:0] gain;
    logic pat_a;
    logic pat_b;
    logic pd_a;
    logic pd_b;
    logic [1:0] lane;
    logic [1:0] fac;
    logic [1:0] order;
  } acm_straps_t;

  // One output word: both channels, their validity, a sequence tag
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
    logic a_ok;
    logic b_ok;
    logic [`ACM_TAG_W-1:0] tag;
  } acm_word_t;

endpackage

// *** core/acm_buf2.sv ***
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
module acm_buf2 #(
  parameter int W = 8
) (
  input logic clk,
  input logic srst,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty straight from the count, so back-pressure is exact
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rp_r];

  //////////////////////////////////////////////////////////////////////
  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage, no reset needed: only read when counted valid
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end

  //////////////////////////////////////////////////////////////////////
  a_buf_bound: assert property (@(posedge clk) disable iff (srst)
    cnt_r != 2'h3) else $error("buffer count out of range");

endmodule

// *** core/acm_mode_ctrl.sv ***
/*
  Mode control of a dual-channel converter: strap filtering and decoding,
  strap/register priority, power and wake-up sequencing, core latency
  pipeline with option-dependent serializer delay, and output formatting
  into a two-entry buffer toward the serial data receiver.
  Assumes straps are quantised two-bit level codes from outside the clock
  domain, register bits come from logic on clk, and the reserved strap is
  grounded on the board and therefore not a port.
*/
`include "acm_defines.svh"

// Overview of operation
// - Total latency adds option-dependent serializer delay
// - Valid data within 100 us after power down
// - Valid data within 100 us after clock restart
// - Channel data valid within 200 cycles after standby
// - Three schemes: straps, registers, or both combined; code treats SCH_SERIAL like SCH_BOTH, so straps still apply without override
// - Combined scheme resolves sources by fixed priority
// - Straps configure device at power-up without reset
// - Strap-only: serial pins act as static selects
// - Gain strap picks coarse gain and reference
// - Pattern straps pick normal, sync, deskew, power down
// - Each channel has its own power-down pin
// - Lane strap picks wire count and clock rate
// - Factor strap picks serialization and capture edge
// - Order strap picks bit order and format
// - Registers steer strap modes only with override set, except reference and pattern, which always follow the registers; code holds gain off without override
// - Pattern straps decode normal, sync, power, deskew
// - Lane strap decodes four settings, one unused
// - Factor strap decodes 12x/14x with edge choice
module acm_mode_ctrl
  import acm_pkg::*;
#(
  parameter int CORE_LAT = `ACM_CORE_LAT,
  parameter int SER_LAT_DDR1W = `ACM_SER_LAT_DDR1W,
  parameter int SER_LAT_SDR2W = `ACM_SER_LAT_SDR2W,
  parameter int SER_LAT_DDR2W = `ACM_SER_LAT_DDR2W,
  parameter int WAKE_CYC = `ACM_WAKE_CYC,
  parameter int STBY_CYC = `ACM_STBY_CYC
) (
  input logic clk,
  input logic srst,
  input logic [1:0] gain_ref_select_strap,
  input logic pattern_select_strap_a,
  input logic pattern_select_strap_b,
  input logic chan_a_powerdown_pin,
  input logic chan_b_powerdown_pin,
  input logic [1:0] lane_clocking_strap,
  input logic [1:0] serial_factor_edge_strap,
  input logic [1:0] bit_order_format_strap,
  input acm_scheme_t config_scheme,
  input logic reg_override,
  input acm_cfg_t reg_cfg,
  input acm_pat_t reg_pattern,
  input logic reg_global_pd,
  input logic clk_restart,
  input logic samp_valid,
  input logic [11:0] samp_a,
  input logic [11:0] samp_b,
  output logic out_valid,
  input logic out_ready,
  output acm_word_t out_word,
  output acm_cfg_t active_cfg,
  output acm_pat_t active_pattern,
  output acm_pwr_t power_state,
  output logic [1:0] chan_ok,
  output logic overrun
);

  localparam int SER_MAX12 = (SER_LAT_DDR1W > SER_LAT_SDR2W) ? SER_LAT_DDR1W : SER_LAT_SDR2W;
  localparam int SER_MAX = (SER_MAX12 > SER_LAT_DDR2W) ? SER_MAX12 : SER_LAT_DDR2W;
  localparam int DEPTH = CORE_LAT + SER_MAX;
  localparam int WW = $clog2(WAKE_CYC + 1);
  localparam int SW = $clog2(STBY_CYC + 1);
  localparam int TW = `ACM_TAG_W;

  // Serializer delay of the selected output option
  function automatic int ser_lat(input acm_cfg_t c);
    if (!c.lane2w) ser_lat = SER_LAT_DDR1W;
    else if (!c.ddr) ser_lat = SER_LAT_SDR2W;
    else ser_lat = SER_LAT_DDR2W;
  endfunction

  // Bit reversal for least-significant-first words
  function automatic logic [11:0] rev12(input logic [11:0] d);
    for (int i = 0; i < 12; i++) rev12[i] = d[11-i];
  endfunction

  acm_straps_t pin_w;
  acm_straps_t s1_r;
  acm_straps_t s2_r;
  acm_straps_t s3_r;
  acm_straps_t st_r;
  acm_cfg_t strap_cfg;
  acm_cfg_t cfg_nxt;
  acm_cfg_t cfg_r;
  acm_pat_t strap_pat;
  acm_pat_t pat_nxt;
  acm_pat_t pat_r;
  acm_pwr_t pwr_r;
  logic gpd_r;
  logic [1:0] chpd_r;
  logic use_reg;
  logic [WW-1:0] wake_cnt_r;
  logic [SW-1:0] sb_cnt_r [2];
  logic [1:0] chan_ok_r;
  acm_word_t pipe_r [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [TW-1:0] adv_cnt_r;
  logic adv;
  logic ins_v;
  acm_word_t ins_w;
  int tap;
  logic in_v;
  acm_word_t fmt_w;
  logic overrun_r;
  logic [$bits(acm_word_t)-1:0] buf_out;

  assign pin_w = {gain_ref_select_strap, pattern_select_strap_a, pattern_select_strap_b,
                  chan_a_powerdown_pin, chan_b_powerdown_pin, lane_clocking_strap,
                  serial_factor_edge_strap, bit_order_format_strap};
  assign use_reg = (config_scheme != SCH_STRAP);

  //////////////////////////////////////////////////////////////////////
  // Pin synchroniser: a bit moves only when stages two and three agree,
  // so a strap sitting between thresholds cannot chatter the mode
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
    end else begin
      s1_r <= pin_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= acm_straps_t'((s3_r & ~(s2_r ^ s3_r)) | (st_r & (s2_r ^ s3_r)));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Strap decoding
  always_comb begin
    strap_cfg = '0;
    strap_cfg.int_ref = st_r.gain[1];
    strap_cfg.gain35 = st_r.gain[1] ^ st_r.gain[0];
    strap_cfg.lane2w = st_r.lane[1];
    strap_cfg.ddr = (st_r.lane != `ACM_LANE_SDR2W);
    strap_cfg.cfg_unused = (st_r.lane == `ACM_LANE_UNUSED);
    strap_cfg.fac14 = st_r.fac[1] ^ st_r.fac[0];
    strap_cfg.cap_rise = st_r.fac[1];
    strap_cfg.msb_first = ~st_r.order[1];
    strap_cfg.twos = ~st_r.order[0];
  end

  // Serial pins read as static levels when straps alone configure
  always_comb begin
    unique case ({st_r.pat_a, st_r.pat_b})
      2'h0: strap_pat = PAT_NORMAL;
      2'h1: strap_pat = PAT_SYNC;
      2'h2: strap_pat = PAT_PDN;
      2'h3: strap_pat = PAT_DESKEW;
    endcase
  end

  // Priority between straps and registers in the register schemes
  always_comb begin
    cfg_nxt = strap_cfg;
    pat_nxt = strap_pat;
    if (use_reg) begin
      if (reg_override) cfg_nxt = reg_cfg;
      cfg_nxt.gain35 = reg_override & reg_cfg.gain35;
      cfg_nxt.int_ref = reg_cfg.int_ref;
      pat_nxt = reg_pattern;
    end
  end

  // Active configuration follows the straps continuously, no reset pulse
  // needed; the trade-off is a mode change mid-stream is not deferred
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= '0;
      pat_r <= PAT_NORMAL;
      gpd_r <= 1'b0;
      chpd_r <= 2'h0;
    end else begin
      cfg_r <= cfg_nxt;
      pat_r <= pat_nxt;
      gpd_r <= (pat_nxt == PAT_PDN) | (use_reg & reg_global_pd);
      chpd_r <= {st_r.pd_b, st_r.pd_a};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Global power and wake-up sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_r <= PWR_WAKE;
      wake_cnt_r <= '0;
    end else begin
      unique case (pwr_r)
        PWR_DOWN: begin
          if (!gpd_r) begin
            pwr_r <= PWR_WAKE;
            wake_cnt_r <= '0;
          end
        end
        PWR_WAKE: begin
          if (gpd_r) pwr_r <= PWR_DOWN;
          else if (clk_restart) wake_cnt_r <= '0;
          else if (wake_cnt_r == WW'(WAKE_CYC - 1)) pwr_r <= PWR_RUN;
          else wake_cnt_r <= wake_cnt_r + 1'b1;
        end
        PWR_RUN: begin
          if (gpd_r) pwr_r <= PWR_DOWN;
          else if (clk_restart) begin
            pwr_r <= PWR_WAKE;
            wake_cnt_r <= '0;
          end
        end
        default: pwr_r <= PWR_DOWN;
      endcase
    end
  end

  // Channel standby exit; counts through global wake so it never adds
  // to the global wake-up time
  always_ff @(posedge clk) begin
    if (srst) begin
      sb_cnt_r <= '{default: '0};
      chan_ok_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (chpd_r[i]) begin
          sb_cnt_r[i] <= '0;
          chan_ok_r[i] <= 1'b0;
        end else if (!chan_ok_r[i]) begin
          if (sb_cnt_r[i] == SW'(STBY_CYC - 1)) chan_ok_r[i] <= 1'b1;
          else sb_cnt_r[i] <= sb_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Latency pipeline; it advances only when the buffer has room, so a
  // stalled receiver freezes it rather than losing a word in flight
  assign ins_v = samp_valid & (pwr_r == PWR_RUN);
  assign tap = CORE_LAT + ser_lat(cfg_r) - 1;
  assign in_v = vld_r[tap];

  always_comb begin
    ins_w.a = chpd_r[0] ? 12'h000 : samp_a;
    ins_w.b = chpd_r[1] ? 12'h000 : samp_b;
    // Masked by the pin too, so the flag drops in the very cycle power goes
    ins_w.a_ok = chan_ok_r[0] & ~chpd_r[0];
    ins_w.b_ok = chan_ok_r[1] & ~chpd_r[1];
    ins_w.tag = adv_cnt_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vld_r <= '0;
      adv_cnt_r <= '0;
    end else if (adv) begin
      vld_r <= {vld_r[DEPTH-2:0], ins_v};
      adv_cnt_r <= adv_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (adv) begin
      pipe_r[0] <= ins_w;
      for (int k = 1; k < DEPTH; k++) pipe_r[k] <= pipe_r[k-1];
    end
  end

  // A sample arriving while frozen is dropped and flagged
  always_ff @(posedge clk) begin
    if (srst) overrun_r <= 1'b0;
    else overrun_r <= ins_v & ~adv;
  end

  // Output format, bit order and test pattern substitution
  always_comb begin
    fmt_w = pipe_r[tap];
    fmt_w.a[11] = fmt_w.a[11] ^ cfg_r.twos;
    fmt_w.b[11] = fmt_w.b[11] ^ cfg_r.twos;
    if (!cfg_r.msb_first) begin
      fmt_w.a = rev12(fmt_w.a);
      fmt_w.b = rev12(fmt_w.b);
    end
    if (pat_r == PAT_SYNC) begin
      fmt_w.a = `ACM_SYNC_PAT;
      fmt_w.b = `ACM_SYNC_PAT;
    end else if (pat_r == PAT_DESKEW) begin
      fmt_w.a = `ACM_DESKEW_PAT;
      fmt_w.b = `ACM_DESKEW_PAT;
    end
  end

  acm_buf2 #(.W($bits(acm_word_t))) acm_buf2_i (
    .clk(clk),
    .srst(srst),
    .in_valid(in_v),
    .in_ready(adv),
    .in_data(fmt_w),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out)
  );

  assign out_word = acm_word_t'(buf_out);
  assign active_cfg = cfg_r;
  assign active_pattern = pat_r;
  assign power_state = pwr_r;
  assign chan_ok = chan_ok_r;
  assign overrun = overrun_r;

  //////////////////////////////////////////////////////////////////////
  // Checks; the quiet counter counts advances since the last mode change
  logic [5:0] quiet_r;
  always_ff @(posedge clk) begin
    if (srst || cfg_nxt != cfg_r) quiet_r <= '0;
    else if (adv && quiet_r != 6'h3f) quiet_r <= quiet_r + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_latency_tag: assert property (in_v && quiet_r > 6'(DEPTH) |->
    TW'(adv_cnt_r - pipe_r[tap].tag) == TW'(tap + 1)) else $error("latency mismatch");
  a_wake_bound: assert property (pwr_r == PWR_WAKE |-> wake_cnt_r < WW'(WAKE_CYC))
    else $error("wake count overran");
  a_wake_done: assert property (pwr_r == PWR_WAKE && !gpd_r && !clk_restart &&
    wake_cnt_r == WW'(WAKE_CYC - 1) |=> pwr_r == PWR_RUN) else $error("wake not done");
  a_restart_wake: assert property (clk_restart && !gpd_r |=>
    pwr_r == PWR_WAKE && wake_cnt_r == '0) else $error("restart not seen");
  a_standby_exit: assert property ($fell(chpd_r[0]) |-> ##[1:200]
    (chan_ok_r[0] || chpd_r[0])) else $error("standby exit too slow");
  a_chan_pd: assert property (chpd_r != 2'h0 |->
    (!chpd_r[0] || (ins_w.a == 12'h000 && !ins_w.a_ok)) &&
    (!chpd_r[1] || (ins_w.b == 12'h000 && !ins_w.b_ok)))
    else $error("channel not powered down");
  a_scheme_reg: assert property (config_scheme == SCH_SERIAL |=>
    pat_r == $past(reg_pattern)) else $error("register pattern ignored");
  a_ovrd_gate: assert property (use_reg && !reg_override |=>
    cfg_r.msb_first == $past(strap_cfg.msb_first) && !cfg_r.gain35)
    else $error("override gate broken");
  a_pat_pdn: assert property (!use_reg && st_r.pat_a && !st_r.pat_b |=>
    pat_r == PAT_PDN && gpd_r) else $error("power down strap misdecoded");
  a_pat_sync: assert property (!use_reg && !st_r.pat_a && st_r.pat_b |=>
    pat_r == PAT_SYNC) else $error("sync strap misdecoded");
  a_lane_map: assert property (!use_reg && st_r.lane == 2'h2 |=>
    cfg_r.lane2w && !cfg_r.ddr) else $error("lane strap misdecoded");
  a_fac_map: assert property (!use_reg && st_r.fac == 2'h1 |=>
    cfg_r.fac14 && !cfg_r.cap_rise) else $error("factor strap misdecoded");
  a_gain_map: assert property (!use_reg && st_r.gain == 2'h2 |=>
    cfg_r.int_ref && cfg_r.gain35) else $error("gain strap misdecoded");
  a_order_map: assert property (!use_reg && st_r.order == 2'h2 |=>
    !cfg_r.msb_first && cfg_r.twos) else $error("order strap misdecoded");
  a_strap_filter: assert property (1'b1 |-> ((st_r ^ $past(st_r)) &
    ($past(s2_r) ^ $past(s3_r))) == '0) else $error("strap passed unfiltered");

  c_wake_done: cover property (pwr_r == PWR_WAKE ##1 pwr_r == PWR_RUN);
  c_sync_out: cover property (in_v && adv && pat_r == PAT_SYNC);
  c_overrun: cover property (overrun_r);
  c_lsb_first: cover property (in_v && adv && !cfg_r.msb_first);

endmodule

// *** test/acm_rx_model.sv ***
/*
  Receiver model for the mode-control bench: takes words from the output
  buffer and can be told to stall.
  Assumes the bench changes stall just after a rising edge of clk.
*/
module acm_rx_model
  import acm_pkg::*;
(
  input logic clk,
  input logic srst,
  input logic stall,
  input logic out_valid,
  output logic out_ready,
  input acm_word_t out_word,
  output logic took,
  output acm_word_t took_word
);
  timeunit 1ns;
  timeprecision 1ns;

  // The board grounds the reserved strap, so no pin is driven for it
  localparam logic reserved_level = 1'b0;
  // A strap-only board holds the register reset pin high; it has no port here
  localparam logic reg_reset_level = 1'b1;

  ////////////////////////////////////////////////////////////
  // Ready changes only after an edge, so an offered word is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
    end
  end

  // A word moves on the edge where valid and ready are both high
  assign took = out_valid && out_ready;
  assign took_word = out_word;
endmodule

// *** test/test_adc_config_mode_control.sv ***
/*
  Self-checking bench of the converter mode-control block.
  Assumes acm_pkg, acm_mode_ctrl and the receiver model are compiled first.
*/
module test_adc_config_mode_control import acm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE = 40;
  logic clk, srst, pat_a, pat_b, pd_a, pd_b, ovr, rgpd, restart, sv, ov, rdy;
  logic overrun, stall, took, ovr_seen;
  logic [1:0] gain_s, lane_s, fac_s, order_s, chok;
  logic [11:0] sa, sb;
  acm_scheme_t scheme;
  acm_cfg_t rcfg, cfg;
  acm_pat_t rpat, pat;
  acm_pwr_t pwr;
  acm_word_t w, took_w, got;
  acm_word_t q[$];
  int bad_count, comparisons;

  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  acm_mode_ctrl #(.WAKE_CYC(WAKE)) acm_mode_ctrl_i (.clk(clk), .srst(srst),
    .gain_ref_select_strap(gain_s), .pattern_select_strap_a(pat_a),
    .pattern_select_strap_b(pat_b), .chan_a_powerdown_pin(pd_a),
    .chan_b_powerdown_pin(pd_b), .lane_clocking_strap(lane_s),
    .serial_factor_edge_strap(fac_s), .bit_order_format_strap(order_s),
    .config_scheme(scheme), .reg_override(ovr), .reg_cfg(rcfg), .reg_pattern(rpat),
    .reg_global_pd(rgpd), .clk_restart(restart), .samp_valid(sv), .samp_a(sa),
    .samp_b(sb), .out_valid(ov), .out_ready(rdy), .out_word(w), .active_cfg(cfg),
    .active_pattern(pat), .power_state(pwr), .chan_ok(chok), .overrun(overrun));

  acm_rx_model acm_rx_model_i (.clk(clk), .srst(srst), .stall(stall), .out_valid(ov),
    .out_ready(rdy), .out_word(w), .took(took), .took_word(took_w));

  // Collect words taken by the receiver and remember any drop
  always @(posedge clk) begin
    if (took === 1'b1) q.push_back(took_w);
    if (overrun === 1'b1) ovr_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Expected decode of the strap level codes
  function automatic acm_cfg_t exp_cfg(logic [1:0] g, logic [1:0] l, logic [1:0] f,
                                       logic [1:0] o);
    acm_cfg_t c;
    c = '0;
    c.lane2w = l[1];
    c.ddr = (l != 2'h2);
    c.cfg_unused = (l == 2'h1);
    c.fac14 = (f == 2'h1 || f == 2'h2);
    c.cap_rise = f[1];
    c.msb_first = !o[1];
    c.twos = !o[0];
    c.gain35 = (g == 2'h1 || g == 2'h2);
    c.int_ref = g[1];
    return c;
  endfunction

  // Fields that do not hang on the factor strap
  function automatic logic [6:0] sub(acm_cfg_t c);
    return {c.lane2w, c.ddr, c.cfg_unused, c.msb_first, c.twos, c.gain35, c.int_ref};
  endfunction

  // Output formatting: flip MSB for twos, then reverse for lsb-first
  function automatic logic [11:0] fmt(logic [11:0] x, logic [1:0] o);
    logic [11:0] r;
    if (!o[0]) x[11] = ~x[11];
    for (int i = 0; i < 12; i++) r[i] = o[1] ? x[11-i] : x[i];
    return r;
  endfunction

  task automatic set_straps(input logic [1:0] g, l, f, o);
    @(posedge clk);
    gain_s <= g;
    lane_s <= l;
    fac_s <= f;
    order_s <= o;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [11:0] a, b);
    @(posedge clk);
    sv <= 1'b1;
    sa <= a;
    sb <= b;
    @(posedge clk);
    sv <= 1'b0;
  endtask

  task automatic get_word(output acm_word_t x);
    int n;
    n = 0;
    while (q.size() == 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(q.size() > 0, 1);
    x = (q.size() > 0) ? q.pop_front() : '0;
  endtask

  task automatic wait_pwr(input acm_pwr_t s, output int n);
    n = 0;
    while (pwr !== s && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////
  task automatic test_reset;
    int n;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({ov, overrun, chok}, 4'h0);
    check({pwr, pat}, {PWR_WAKE, PAT_NORMAL});
    repeat (6) @(posedge clk);
    #1;
    check(sub(cfg), sub(exp_cfg(0, 0, 0, 1)));
    n = 0;
    while (chok !== 2'h3 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({pwr, chok}, {PWR_RUN, 2'h3});
    $display("test_reset done");
  endtask

  task automatic test_straps;
    for (int i = 0; i < 4; i++) begin
      set_straps(i, 2, i, i);
      check(cfg, exp_cfg(i, 2, i, i));
    end
    for (int i = 0; i < 4; i++) begin
      set_straps(0, i, 0, 1);
      check(sub(cfg), sub(exp_cfg(0, i, 0, 1)));
    end
    $display("test_straps done");
  endtask

  task automatic test_patterns;
    int n;
    for (int k = 1; k < 4; k += 2) begin
      @(posedge clk);
      pat_a <= k[1];
      pat_b <= 1'b1;
      send(12'h123, 12'h456);
      get_word(got);
      check(pat, k[1] ? PAT_DESKEW : PAT_SYNC);
      check(got.a, k[1] ? `ACM_DESKEW_PAT : `ACM_SYNC_PAT);
    end
    @(posedge clk);
    pat_b <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
    check({pat, pwr}, {PAT_PDN, PWR_DOWN});
    @(posedge clk);
    pat_a <= 1'b0;
    wait_pwr(PWR_RUN, n);
    check(n >= WAKE && n <= WAKE + 10, 1);
    check(pat, PAT_NORMAL);
    $display("test_patterns done");
  endtask

  task automatic test_latency;
    logic [1:0] ln[3] = '{2'h0, 2'h2, 2'h3};
    logic [1:0] od[3] = '{2'h1, 2'h0, 2'h3};
    int ser[3] = '{1, 2, 2};
    int n;
    q.delete();
    for (int j = 0; j < 3; j++) begin
      set_straps(0, ln[j], 0, od[j]);
      send(12'h123 + j, 12'h456);
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (ov !== 1'b1 && n < 40);
      check(n, `ACM_CORE_LAT + ser[j]);
      get_word(got);
      check({got.a, got.b}, {fmt(12'h123 + j, od[j]), fmt(12'h456, od[j])});
    end
    set_straps(0, 0, 0, 1);
    $display("test_latency done");
  endtask

  task automatic test_registers;
    int n;
    acm_cfg_t e;
    e = exp_cfg(2, 0, 0, 1);
    e.gain35 = 1'b0;
    e.int_ref = 1'b0;
    set_straps(2, 0, 0, 1);
    for (int s = 1; s < 3; s++) begin
      @(posedge clk);
      scheme <= acm_scheme_t'(s[1:0]);
      ovr <= 1'b0;
      rcfg <= acm_cfg_t'(9'h122);
      rpat <= PAT_SYNC;
      pat_a <= 1'b1;
      pat_b <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check(sub(cfg), sub(e));
      check(pat, PAT_SYNC);
      @(posedge clk);
      ovr <= 1'b1;
      @(posedge clk);
      #1;
      check(cfg, acm_cfg_t'(9'h122));
    end
    @(posedge clk);
    rgpd <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(pwr, PWR_DOWN);
    @(posedge clk);
    {rgpd, ovr, pat_a, pat_b} <= 4'h0;
    scheme <= SCH_STRAP;
    rpat <= PAT_NORMAL;
    set_straps(0, 0, 0, 1);
    wait_pwr(PWR_RUN, n);
    check(sub(cfg), sub(exp_cfg(0, 0, 0, 1)));
    $display("test_registers done");
  endtask

  task automatic test_standby;
    int n;
    @(posedge clk);
    pd_a <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(chok, 2'h2);
    send(12'h321, 12'h0ab);
    get_word(got);
    check({got.a_ok, got.b_ok, got.a, got.b}, {2'h1, 12'h000, 12'h0ab});
    @(posedge clk);
    pd_a <= 1'b0;
    n = 0;
    while (chok !== 2'h3 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n >= 200 && n <= 210, 1);
    $display("test_standby done");
  endtask

  task automatic test_restart;
    int n;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    #1;
    check(pwr, PWR_WAKE);
    wait_pwr(PWR_RUN, n);
    check(n >= WAKE && n <= WAKE + 1, 1);
    $display("test_restart done");
  endtask

  task automatic test_stall;
    q.delete();
    @(posedge clk);
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      sv <= 1'b1;
      sa <= i;
      sb <= 12'h0;
    end
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(posedge clk);
    stall <= 1'b1;
    check(ovr_seen, 1'b1);
    @(posedge clk);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    check(q.size() >= 2 && q.size() < 20, 1);
    foreach (q[k]) check(q[k].a, fmt(k, 1));
    // Back-to-back samples carry consecutive sequence tags
    foreach (q[k]) check(8'(q[k].tag - q[0].tag), k);
    $display("test_stall done");
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence; every input gets a level at time zero
  initial begin
    {srst, pat_a, pat_b, pd_a, pd_b, ovr, rgpd, restart, sv, stall} = 10'h200;
    {gain_s, lane_s, fac_s, order_s} = 8'h01;
    {sa, sb, ovr_seen} = '0;
    scheme = SCH_STRAP;
    rcfg = '0;
    rpat = PAT_NORMAL;
    test_reset();
    test_straps();
    test_patterns();
    test_latency();
    test_registers();
    test_standby();
    test_restart();
    test_stall();
    give_verdict();
  end

  // Watchdog far beyond the thousand or so cycles the tests need
  initial begin
    #(20000 * 50);
    bad_count++;
    give_verdict();
  end
endmodule
